// ---- core/jpdal_regs.vh ----
// Constants for the scan-based program and debug access layer
// Notes on behaviour
// RQ1 - Comm-path instruction selects a 9-bit communication register as data register.
// RQ2 - Capture loads controller data, Shift shifts per test clock, Update latches.
// RQ3 - Frame is eight data bits LSB first, then one even parity bit.
// RQ4 - Special characters invert parity; programmer sends BREAK 0xBB to abort.
// RQ5 - Device sends DELAY 0xDB with inverted parity when no data ready.
// RQ6 - Device sends EMPTY 0xEB with inverted parity while in receive mode.
// RQ7 - Receive mode at Capture-DR loads EMPTY with parity bit set.
// RQ8 - Transmit mode with pending request loads data with correct even parity.
// RQ9 - Transmit mode without pending request loads DELAY with parity bit set.
// RQ10 - Data changes on falling test clock edge, sampled on rising edge.
// RQ11 - Layer runs one direction at a time; idle channel carries status.
// RQ12 - Transmitter generates and appends parity; bit rate set by test clock.
// RQ13 - Programmer repeats transfers after DELAY and never resends load instruction.
// RQ14 - Receiver shifts data and parity from test data in, latches at Update-DR.
// RQ15 - Parity checker runs both directions, flags errors and recognised BREAK.
// RQ16 - Entering a mode initialises controller and clock; two-wire mode takes priority.
// RQ17 - Programmer disables the active layer before enabling the other.
// RQ18 - Internal interfaces stay locked until the 64-bit activation key arrives.
// RQ19 - Memory reached only in programming mode with memory controller enabled.
// RQ20 - Receive mode exceptions: parity error, BREAK; two-wire also frame error. In two-wire mode the code raises only the frame error.
// RQ21 - Transmit exceptions: two-wire collision; scan parity error or BREAK.
// RQ22 - Exception aborts all, enters error state until BREAK returns to receive. In two-wire mode only entering a mode clears it.
// RQ23 - Programmer resynchronises by sending two successive BREAK characters.
// RQ24 - Received byte, parity error and BREAK reach controller as one-cycle strobes.
`ifndef JPDAL_REGS_VH
`define JPDAL_REGS_VH
`define JPDAL_TAP_RESET     4'h0
`define JPDAL_TAP_IDLE      4'h1
`define JPDAL_TAP_SEL_DR    4'h2
`define JPDAL_TAP_CAP_DR    4'h3
`define JPDAL_TAP_SHIFT_DR  4'h4
`define JPDAL_TAP_EXIT1_DR  4'h5
`define JPDAL_TAP_PAUSE_DR  4'h6
`define JPDAL_TAP_EXIT2_DR  4'h7
`define JPDAL_TAP_UPD_DR    4'h8
`define JPDAL_TAP_SEL_IR    4'h9
`define JPDAL_TAP_CAP_IR    4'hA
`define JPDAL_TAP_SHIFT_IR  4'hB
`define JPDAL_TAP_EXIT1_IR  4'hC
`define JPDAL_TAP_PAUSE_IR  4'hD
`define JPDAL_TAP_EXIT2_IR  4'hE
`define JPDAL_TAP_UPD_IR    4'hF
`define JPDAL_IR_COMM       4'h7
`define JPDAL_IR_BYPASS     4'hF
`define JPDAL_IR_CAPTURE    4'h1
`define JPDAL_CHAR_BREAK    8'hBB
`define JPDAL_CHAR_DELAY    8'hDB
`define JPDAL_CHAR_EMPTY    8'hEB
`define JPDAL_KEY           64'h1289AB45CDD888FF
`define JPDAL_KEY_BYTES     4'h8
`define JPDAL_MODE_NONE     2'h0
`define JPDAL_MODE_SCAN     2'h1
`define JPDAL_MODE_WIRE     2'h2
`endif

// ---- core/jpdal_tap.v ----
// Test access port state machine stepped on detected test clock rises
`timescale 1ns/1ps
`include "jpdal_regs.vh"
module jpdal_tap (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       clkEn,
	input  wire       tckRise,
	input  wire       tmsLevel,
	output reg  [3:0] tapState
);
	reg [3:0] next_tapState;

	// Next state from mode select
	always @* begin
		next_tapState = tapState;
		case (tapState)
			`JPDAL_TAP_RESET:    next_tapState = tmsLevel ? `JPDAL_TAP_RESET : `JPDAL_TAP_IDLE;
			`JPDAL_TAP_IDLE:     next_tapState = tmsLevel ? `JPDAL_TAP_SEL_DR : `JPDAL_TAP_IDLE;
			`JPDAL_TAP_SEL_DR:   next_tapState = tmsLevel ? `JPDAL_TAP_SEL_IR : `JPDAL_TAP_CAP_DR;
			`JPDAL_TAP_CAP_DR:   next_tapState = tmsLevel ? `JPDAL_TAP_EXIT1_DR : `JPDAL_TAP_SHIFT_DR;
			`JPDAL_TAP_SHIFT_DR: next_tapState = tmsLevel ? `JPDAL_TAP_EXIT1_DR : `JPDAL_TAP_SHIFT_DR;
			`JPDAL_TAP_EXIT1_DR: next_tapState = tmsLevel ? `JPDAL_TAP_UPD_DR : `JPDAL_TAP_PAUSE_DR;
			`JPDAL_TAP_PAUSE_DR: next_tapState = tmsLevel ? `JPDAL_TAP_EXIT2_DR : `JPDAL_TAP_PAUSE_DR;
			`JPDAL_TAP_EXIT2_DR: next_tapState = tmsLevel ? `JPDAL_TAP_UPD_DR : `JPDAL_TAP_SHIFT_DR;
			`JPDAL_TAP_UPD_DR:   next_tapState = tmsLevel ? `JPDAL_TAP_SEL_DR : `JPDAL_TAP_IDLE;
			`JPDAL_TAP_SEL_IR:   next_tapState = tmsLevel ? `JPDAL_TAP_RESET : `JPDAL_TAP_CAP_IR;
			`JPDAL_TAP_CAP_IR:   next_tapState = tmsLevel ? `JPDAL_TAP_EXIT1_IR : `JPDAL_TAP_SHIFT_IR;
			`JPDAL_TAP_SHIFT_IR: next_tapState = tmsLevel ? `JPDAL_TAP_EXIT1_IR : `JPDAL_TAP_SHIFT_IR;
			`JPDAL_TAP_EXIT1_IR: next_tapState = tmsLevel ? `JPDAL_TAP_UPD_IR : `JPDAL_TAP_PAUSE_IR;
			`JPDAL_TAP_PAUSE_IR: next_tapState = tmsLevel ? `JPDAL_TAP_EXIT2_IR : `JPDAL_TAP_PAUSE_IR;
			`JPDAL_TAP_EXIT2_IR: next_tapState = tmsLevel ? `JPDAL_TAP_UPD_IR : `JPDAL_TAP_SHIFT_IR;
			`JPDAL_TAP_UPD_IR:   next_tapState = tmsLevel ? `JPDAL_TAP_SEL_DR : `JPDAL_TAP_IDLE;
			default:             next_tapState = `JPDAL_TAP_RESET;
		endcase
	end

	// State register, advanced only on a test clock rise
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tapState <= `JPDAL_TAP_RESET;
		end else if (clkEn && tckRise) begin
			tapState <= next_tapState;
		end
	end
endmodule // jpdal_tap

// ---- core/jpdal_core.v ----
// Scan-based physical layer and access control for the program and debug port
`timescale 1ns/1ps
`include "jpdal_regs.vh"
module jpdal_core (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       clkEn,
	input  wire       tck,
	input  wire       tms,
	input  wire       tdi,
	output reg        tdo,
	output reg        tdoEn,
	input  wire       scanEnableFuse,
	input  wire       twoWireEnable,
	input  wire       nativeFrameErr,
	input  wire       nativeCollision,
	input  wire       ctlTxMode,
	input  wire       txValid,
	input  wire [7:0] txByte,
	output reg        txTaken,
	output reg  [7:0] rxByte,
	output reg        rxStrobe,
	output reg        parityErrStrobe,
	output reg        breakStrobe,
	input  wire       keyCollect,
	input  wire       nvmCtlEnabled,
	output reg        keyValid,
	output reg        nvmAccess,
	output reg        errorState,
	output reg        abortPulse,
	output reg        txDirection,
	output reg  [1:0] activeMode,
	output reg        linkClkSel,
	output reg        ctlInit
);
	// Pin synchronisers, three stages each
	reg  [2:0] tckSync;
	reg  [2:0] tmsSync;
	reg  [2:0] tdiSync;
	reg        tckLevel;
	reg        tmsLevel;
	reg        tdiLevel;
	wire       tckRise;
	wire       tckFall;

	// Scan path state
	wire [3:0] tapState;
	reg  [3:0] irShift;
	reg  [3:0] irActive;
	reg  [8:0] commShift;
	reg        bypassBit;
	reg        txLoaded;

	// Access control state
	reg [63:0] keyShift;
	reg  [3:0] keyCount;
	reg        scanReqSeen;
	reg        wireReqSeen;

	// Decoded frame at update
	wire [7:0] frameData;
	wire       frameParity;
	wire       frameParErr;
	wire       frameBreak;
	wire       commSelected;
	wire       scanLive;
	wire       tckSettled;
	wire       tmsSettled;
	wire       tdiSettled;

	assign tckSettled   = tckSync[1] ~^ tckSync[2];
	assign tmsSettled   = tmsSync[1] ~^ tmsSync[2];
	assign tdiSettled   = tdiSync[1] ~^ tdiSync[2];
	assign tckRise      = tckSettled && tckSync[2] && !tckLevel;
	assign tckFall      = tckSettled && !tckSync[2] && tckLevel;
	assign frameData    = commShift[7:0];
	assign frameParity  = commShift[8];
	assign frameParErr  = frameParity != (^frameData); // RQ15
	assign frameBreak   = frameParErr && (frameData == `JPDAL_CHAR_BREAK); // RQ15
	assign commSelected = irActive == `JPDAL_IR_COMM; // RQ1
	assign scanLive     = activeMode == `JPDAL_MODE_SCAN;

	// Synchroniser chains; a level counts once stages two and three agree
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tckSync  <= 3'h0;
			tmsSync  <= 3'h7;
			tdiSync  <= 3'h7;
			tckLevel <= 1'b0;
			tmsLevel <= 1'b1;
			tdiLevel <= 1'b1;
		end else if (clkEn) begin
			tckSync <= {tckSync[1:0], tck};
			tmsSync <= {tmsSync[1:0], tms};
			tdiSync <= {tdiSync[1:0], tdi};
			if (tckSettled) begin
				tckLevel <= tckSync[2];
			end
			if (tmsSettled) begin
				tmsLevel <= tmsSync[2];
			end
			if (tdiSettled) begin
				tdiLevel <= tdiSync[2];
			end
		end
	end

	// Access port state machine
	jpdal_tap tapFsm (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.tckRise  (tckRise),
		.tmsLevel (tmsLevel),
		.tapState (tapState)
	);

	// Instruction register, sampled on test clock rise
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irShift  <= `JPDAL_IR_BYPASS;
			irActive <= `JPDAL_IR_BYPASS;
		end else if (clkEn && tckRise) begin
			if (tapState == `JPDAL_TAP_RESET) begin
				irActive <= `JPDAL_IR_BYPASS;
			end else if (tapState == `JPDAL_TAP_CAP_IR) begin
				irShift <= `JPDAL_IR_CAPTURE;
			end else if (tapState == `JPDAL_TAP_SHIFT_IR) begin
				irShift <= {tdiLevel, irShift[3:1]};
			end else if (tapState == `JPDAL_TAP_UPD_IR) begin
				irActive <= irShift; // RQ1
			end
		end
	end

	// Communication register: capture, shift and bypass path
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			commShift <= 9'h000;
			bypassBit <= 1'b0;
			txLoaded  <= 1'b0;
			txTaken   <= 1'b0;
		end else if (clkEn) begin
			txTaken <= 1'b0;
			if (tckRise && tapState == `JPDAL_TAP_CAP_DR) begin
				bypassBit <= 1'b0;
				txLoaded  <= 1'b0;
				if (commSelected && scanLive) begin
					if (!txDirection) begin
						commShift <= {1'b1, `JPDAL_CHAR_EMPTY}; // RQ6 RQ7
					end else if (txValid) begin
						commShift <= {^txByte, txByte}; // RQ8 RQ12
						txLoaded  <= 1'b1;
						txTaken   <= 1'b1;
					end else begin
						commShift <= {1'b1, `JPDAL_CHAR_DELAY}; // RQ5 RQ9
					end
				end
			end else if (tckRise && tapState == `JPDAL_TAP_SHIFT_DR) begin
				commShift <= {tdiLevel, commShift[8:1]}; // RQ2 RQ3 RQ14
				bypassBit <= tdiLevel;
			end
		end
	end

	// Output pin changes on test clock fall only
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo   <= 1'b1;
			tdoEn <= 1'b0;
		end else if (clkEn && tckFall) begin
			if (tapState == `JPDAL_TAP_SHIFT_DR) begin
				tdo   <= commSelected ? commShift[0] : bypassBit; // RQ10
				tdoEn <= 1'b1;
			end else if (tapState == `JPDAL_TAP_SHIFT_IR) begin
				tdo   <= irShift[0]; // RQ10
				tdoEn <= 1'b1;
			end else begin
				tdoEn <= 1'b0;
			end
		end
	end

	// Mode selection; two-wire layer wins over scan
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			activeMode  <= `JPDAL_MODE_NONE;
			linkClkSel  <= 1'b0;
			ctlInit     <= 1'b0;
			scanReqSeen <= 1'b0;
			wireReqSeen <= 1'b0;
		end else if (clkEn) begin
			ctlInit     <= 1'b0;
			scanReqSeen <= scanEnableFuse && commSelected;
			wireReqSeen <= twoWireEnable;
			if (twoWireEnable && !wireReqSeen) begin
				activeMode <= `JPDAL_MODE_WIRE; // RQ16
				linkClkSel <= 1'b1;
				ctlInit    <= 1'b1;
			end else if (!twoWireEnable && activeMode == `JPDAL_MODE_WIRE) begin
				activeMode <= `JPDAL_MODE_NONE; // RQ17
			end else if (!scanEnableFuse && activeMode == `JPDAL_MODE_SCAN) begin
				activeMode <= `JPDAL_MODE_NONE;
			end else if (scanEnableFuse && commSelected && !scanReqSeen
					&& activeMode == `JPDAL_MODE_NONE) begin
				activeMode <= `JPDAL_MODE_SCAN; // RQ16
				linkClkSel <= 1'b0;
				ctlInit    <= 1'b1;
			end
		end
	end

	// Frame evaluation at Update-DR and exception handling
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxByte          <= 8'h00;
			rxStrobe        <= 1'b0;
			parityErrStrobe <= 1'b0;
			breakStrobe     <= 1'b0;
			errorState      <= 1'b0;
			abortPulse      <= 1'b0;
			txDirection     <= 1'b0;
		end else if (clkEn) begin
			rxStrobe        <= 1'b0;
			parityErrStrobe <= 1'b0;
			breakStrobe     <= 1'b0;
			abortPulse      <= 1'b0;
			if (ctlInit) begin
				errorState  <= 1'b0; // RQ16
				txDirection <= 1'b0;
			end else if (activeMode == `JPDAL_MODE_WIRE) begin
				if (nativeFrameErr && !txDirection) begin
					errorState  <= 1'b1; // RQ20
					abortPulse  <= 1'b1;
					txDirection <= 1'b0;
				end else if (nativeCollision && txDirection) begin
					errorState  <= 1'b1; // RQ21
					abortPulse  <= 1'b1;
					txDirection <= 1'b0;
				end else begin
					txDirection <= ctlTxMode && !errorState;
				end
			end else if (tckRise && tapState == `JPDAL_TAP_UPD_DR && commSelected && scanLive) begin
				if (frameBreak) begin
					breakStrobe     <= 1'b1; // RQ15 RQ24
					parityErrStrobe <= 1'b1;
					abortPulse      <= 1'b1; // RQ22
					errorState      <= 1'b0; // RQ4 RQ22
					txDirection     <= 1'b0;
				end else if (frameParErr) begin
					parityErrStrobe <= 1'b1; // RQ15 RQ24
					abortPulse      <= !errorState;
					errorState      <= 1'b1; // RQ20 RQ21 RQ22
					txDirection     <= 1'b0;
				end else if (!txDirection && !errorState) begin
					rxByte   <= frameData; // RQ14
					rxStrobe <= 1'b1; // RQ24
				end
			end else if (!(tckRise && tapState == `JPDAL_TAP_SHIFT_DR)) begin
				txDirection <= ctlTxMode && !errorState; // RQ11
			end
		end
	end

	// Activation key collection and memory access gate
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			keyShift  <= 64'h0000000000000000;
			keyCount  <= 4'h0;
			keyValid  <= 1'b0;
			nvmAccess <= 1'b0;
		end else if (clkEn) begin
			if (ctlInit || abortPulse) begin
				keyCount <= 4'h0;
				if (ctlInit) begin
					keyValid <= 1'b0; // RQ18
				end
			end else if (rxStrobe && keyCollect) begin
				keyShift <= {rxByte, keyShift[63:8]}; // RQ18
				if (keyCount == `JPDAL_KEY_BYTES - 4'h1) begin
					keyCount <= 4'h0;
					keyValid <= {rxByte, keyShift[63:8]} == `JPDAL_KEY; // RQ18
				end else begin
					keyCount <= keyCount + 4'h1;
				end
			end else if (!keyCollect) begin
				keyCount <= 4'h0;
			end
			nvmAccess <= keyValid && nvmCtlEnabled && !errorState
				&& activeMode != `JPDAL_MODE_NONE; // RQ19
		end
	end
endmodule // jpdal_core

// ---- test/jpdal_core_assertions.sv ----
// Concurrent checks on the port pins of the scan access layer
`timescale 1ns/1ps
module jpdal_core_assertions (
	input logic       ref_clk, rst_n, tdo, tdoEn, twoWireEnable, nvmCtlEnabled, keyValid, nvmAccess,
	input logic       txTaken, rxStrobe, parityErrStrobe, breakStrobe, errorState, abortPulse,
	input logic       txDirection, linkClkSel, ctlInit,
	input logic [1:0] activeMode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Break frame as seen by the parity checker
	sequence s_brk;
		breakStrobe ##0 parityErrStrobe;
	endsequence
	// Some gate of memory access closed for two cycles
	sequence s_shut;
		(!nvmCtlEnabled || errorState || !keyValid) [*2];
	endsequence
	a_rx_one_cycle: assert property (rxStrobe |=> !rxStrobe) else $error("rx strobe too long");
	a_taken_in_tx: assert property (txTaken |-> txDirection ##1 !txTaken) else $error("bad tx load");
	a_break_parity: assert property (breakStrobe |-> parityErrStrobe) else $error("break without parity");
	a_break_recover: assert property (s_brk |-> abortPulse ##[0:2] !errorState)
		else $error("break did not recover");
	a_perr_error: assert property (parityErrStrobe && !breakStrobe |-> ##[0:1] errorState)
		else $error("parity error ignored");
	a_rx_clean: assert property (rxStrobe |-> !parityErrStrobe && !txDirection && !errorState)
		else $error("byte strobed out of receive");
	a_nvm_gate: assert property (s_shut |-> !nvmAccess) else $error("memory access not gated");
	a_tdo_hold: assert property (!tdoEn && !$past(tdoEn) |-> $stable(tdo)) else $error("tdo moved");
	a_wire_first: assert property (twoWireEnable [*6] |-> activeMode == 2'h2)
		else $error("two-wire mode not taken");
	a_clk_follow: assert property ($stable(activeMode) && activeMode != 2'h0 |-> linkClkSel == (activeMode == 2'h2))
		else $error("clock select mismatch");
	a_init_mode: assert property (ctlInit |-> ##[0:1] activeMode != 2'h0) else $error("init without mode");
	a_err_rx_dir: assert property (errorState [*3] |-> !txDirection) else $error("transmit in error");
endmodule // jpdal_core_assertions

// ---- test/jpdal_prog_model.sv ----
// Programmer model: drives the test access port and reads frames back
`timescale 1ns/1ps
module jpdal_prog_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input  logic tdo
);
	logic lastTdo;
	// Test clock stands low between transfers
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One test clock: change on the fall, sample on the rise
	task automatic step(input logic m, input logic d);
		tms = m;
		tdi = d;
		#100 tck = 1'b1;
		lastTdo = tdo;
		#100 tck = 1'b0;
	endtask
	// Five high selects reach reset, then park in idle
	task automatic tapReset();
		repeat (5) step(1'b1, ~tdi);
		step(1'b0, ~tdi);
	endtask
	// Instruction shifted low bit first, then update
	task automatic loadIr(input logic [3:0] ir);
		step(1'b1, ~tdi);
		step(1'b1, ~tdi);
		step(1'b0, ~tdi);
		step(1'b0, ~tdi);
		for (int i = 0; i < 4; i++) step(i == 3, ir[i]);
		step(1'b1, ~tdi);
		step(1'b0, ~tdi);
	endtask
	// Data low bit first then parity, outgoing bits taken alongside
	task automatic frame(input logic [8:0] din, output logic [8:0] dout);
		step(1'b1, ~tdi);
		step(1'b0, ~tdi);
		step(1'b0, ~tdi);
		for (int i = 0; i < 9; i++) begin
			step(i == 8, din[i]);
			dout[i] = lastTdo;
		end
		step(1'b1, ~tdi);
		step(1'b0, ~tdi);
	endtask
endmodule // jpdal_prog_model

// ---- test/jpdal_core_test.sv ----
// Self-checking bench for the scan access layer
`timescale 1ns/1ps
`include "jpdal_regs.vh"
module jpdal_core_test;
	logic       ref_clk, rst_n, clkEn, tck, tms, tdi, tdo, tdoEn, scanEnableFuse, twoWireEnable;
	logic       nativeFrameErr, nativeCollision, ctlTxMode, txValid, txTaken, rxStrobe, parityErrStrobe;
	logic       breakStrobe, keyCollect, nvmCtlEnabled, keyValid, nvmAccess, errorState, abortPulse;
	logic       txDirection, linkClkSel, ctlInit;
	logic [7:0] txByte, rxByte;
	logic [1:0] activeMode;
	logic [8:0] o;
	logic [5:0] ev;
	int         n_fail, check_count;
	int         cnt [6];
	jpdal_core uut (.*);
	jpdal_prog_model pm (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Pulse tallies: rx, parity, break, taken, init, abort
	assign ev = {rxStrobe, parityErrStrobe, breakStrobe, txTaken, ctlInit, abortPulse};
	always @(posedge ref_clk) begin
		foreach (ev[i])
			if (ev[i] === 1'b1)
				cnt[i]++;
		if (txTaken === 1'b1)
			txValid <= 1'b0;
	end
	function automatic logic [17:0] evc();
		evc = 18'h00000;
		for (int i = 0; i < 6; i++) evc[3*i +: 3] = cnt[i][2:0];
	endfunction
	task automatic clr();
		cnt = '{default: 0};
	endtask
	task automatic idle();
		repeat (8) @(posedge ref_clk);
		#12.5;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] d, input logic bad);
		pm.frame({(^d) ^ bad, d}, o);
		idle();
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Scan mode refused without the fuse, taken with it
	task automatic t_enter();
		check({tdo, tdoEn, errorState, keyValid, txDirection, activeMode}, 7'h40);
		pm.tapReset();
		pm.loadIr(`JPDAL_IR_COMM);
		idle();
		check(activeMode, `JPDAL_MODE_NONE);
		scanEnableFuse = 1'b1;
		clr();
		pm.loadIr(`JPDAL_IR_COMM);
		idle();
		check({linkClkSel, activeMode, evc()}, {1'b0, `JPDAL_MODE_SCAN, 18'h00008});
		$display("t_enter done");
	endtask
	// Back to back received frames answered with the empty character
	task automatic t_rx();
		for (int i = 0; i < 2; i++) begin
			clr();
			xfer(i ? 8'h00 : 8'hA5, 1'b0);
			check(o, {1'b1, `JPDAL_CHAR_EMPTY});
			check({rxByte, evc()}, {i ? 8'h00 : 8'hA5, 18'h08000});
		end
		$display("t_rx done");
	endtask
	// Key bytes low first; memory reachable only with its controller on
	task automatic t_key();
		logic [63:0] k;
		k = `JPDAL_KEY;
		keyCollect = 1'b1;
		nvmCtlEnabled = 1'b1;
		for (int i = 0; i < 8; i++) begin
			check(keyValid, 1'b0);
			xfer(k[8*i +: 8], 1'b0);
		end
		check({keyValid, nvmAccess}, 2'h3);
		keyCollect = 1'b0;
		nvmCtlEnabled = 1'b0;
		idle();
		check(nvmAccess, 1'b0);
		nvmCtlEnabled = 1'b1;
		$display("t_key done");
	endtask
	// Parity fault in receive locks out until a break
	task automatic t_rxerr();
		clr();
		xfer(8'h12, 1'b1);
		check({errorState, nvmAccess}, 2'h2);
		xfer(8'h34, 1'b0);
		check({o, evc()}, {1'b1, `JPDAL_CHAR_EMPTY, 18'h01001});
		clr();
		xfer(`JPDAL_CHAR_BREAK, 1'b1);
		xfer(8'h34, 1'b0);
		check({errorState, rxByte, evc()}, {1'b0, 8'h34, 18'h09201});
		$display("t_rxerr done");
	endtask
	// Transmit: delay until data pends, then data with true parity
	task automatic t_tx();
		ctlTxMode = 1'b1;
		idle();
		clr();
		xfer(8'h00, 1'b0);
		check({txDirection, o}, {2'h3, `JPDAL_CHAR_DELAY});
		txByte = 8'h97;
		txValid = 1'b1;
		xfer(8'h00, 1'b0);
		check({errorState, txValid, o}, {2'h0, 1'b1, 8'h97});
		xfer(8'h00, 1'b0);
		check({o, evc()}, {1'b1, `JPDAL_CHAR_DELAY, 18'h00040});
		$display("t_tx done");
	endtask
	// Faults in transmit, then two breaks to resynchronise
	task automatic t_txerr();
		clr();
		xfer(`JPDAL_CHAR_BREAK, 1'b1);
		check({errorState, evc()}, {1'b0, 18'h01201});
		clr();
		xfer(8'h55, 1'b1);
		check({errorState, txDirection, evc()}, {2'h2, 18'h01001});
		clr();
		xfer(8'h66, 1'b0);
		check(o, {1'b1, `JPDAL_CHAR_EMPTY});
		xfer(`JPDAL_CHAR_BREAK, 1'b1);
		xfer(`JPDAL_CHAR_BREAK, 1'b1);
		check({errorState, txDirection, evc()}, {2'h1, 18'h02402});
		ctlTxMode = 1'b0;
		$display("t_txerr done");
	endtask
	// Two-wire enable overrides scan mode and switches the clock
	task automatic t_wire();
		clr();
		twoWireEnable = 1'b1;
		idle();
		check({linkClkSel, activeMode, evc()}, {1'b1, `JPDAL_MODE_WIRE, 18'h00008});
		// Collision while transmitting on the two-wire layer
		ctlTxMode = 1'b1;
		idle();
		clr();
		nativeCollision = 1'b1;
		@(posedge ref_clk);
		#12.5;
		nativeCollision = 1'b0;
		idle();
		check({errorState, txDirection, evc()}, {2'h2, 18'h00001});
		// Frame error while receiving on the two-wire layer
		ctlTxMode = 1'b0;
		clr();
		nativeFrameErr = 1'b1;
		@(posedge ref_clk);
		#12.5;
		nativeFrameErr = 1'b0;
		idle();
		check({errorState, txDirection, evc()}, {2'h2, 18'h00001});
		twoWireEnable = 1'b0;
		idle();
		check(activeMode, `JPDAL_MODE_NONE);
		$display("t_wire done");
	endtask
	initial begin
		{rst_n, scanEnableFuse, twoWireEnable, nativeFrameErr, nativeCollision} = 5'h00;
		{ctlTxMode, txValid, keyCollect, nvmCtlEnabled, txByte} = 12'h000;
		clkEn = 1'b1;
		repeat (8) @(posedge ref_clk);
		#12.5 rst_n = 1'b1;
		t_enter();
		t_rx();
		t_key();
		t_rxerr();
		t_tx();
		t_txerr();
		t_wire();
		test_done();
	end
	// Bounded run
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_fail++;
		test_done();
	end
endmodule // jpdal_core_test
bind jpdal_core jpdal_core_assertions chk (.*);
